/* File: include/uart_ident_pkg.sv */
package uart_ident_pkg;
    // Register byte addresses on the Avalon-MM port
    localparam logic [3:0] ADDR_IDENT      = 4'h0;
    localparam logic [3:0] ADDR_LINE_FMT   = 4'h4;
    localparam logic [3:0] ADDR_FIFO_CTRL  = 4'h8;
    localparam logic [3:0] ADDR_SOURCES    = 4'hC;

    // Identification codes, bits 3..0
    localparam logic [3:0] ID_LINE_STATUS  = 4'h6;
    localparam logic [3:0] ID_RX_AVAIL     = 4'h4;
    localparam logic [3:0] ID_RX_TIMEOUT   = 4'hC;
    localparam logic [3:0] ID_TX_EMPTY     = 4'h2;
    localparam logic [3:0] ID_MODEM        = 4'h0;
    localparam logic [3:0] ID_NONE         = 4'h1;

    // Line format and FIFO control field positions
    localparam int LF_DIVISOR  = 7;
    localparam int LF_BREAK    = 6;
    localparam int LF_PAR_HI   = 5;
    localparam int LF_PAR_LO   = 3;
    localparam int LF_STOP     = 2;
    localparam int LF_LEN_HI   = 1;
    localparam int LF_LEN_LO   = 0;
    localparam int FC_ENABLE   = 0;

    localparam logic [7:0] LINE_FMT_RESET  = 8'h00;
    localparam logic [7:0] IDENT_RESET     = 8'h01;
    localparam logic [1:0] FIFO_ON_MARK    = 2'h3;

    // Parity field encodings
    localparam logic [2:0] PAR_EVEN        = 3'h3;
    localparam logic [2:0] PAR_FORCE0      = 3'h7;

    typedef enum logic [1:0] {
        PARITY_NONE = 2'h0,
        PARITY_ODD  = 2'h1,
        PARITY_EVEN = 2'h2,
        PARITY_ZERO = 2'h3
    } parity_type;

    typedef enum logic [2:0] {
        SRC_LINE    = 3'h0,
        SRC_RXAVAIL = 3'h1,
        SRC_RXTIME  = 3'h2,
        SRC_TXEMPTY = 3'h3,
        SRC_MODEM   = 3'h4
    } source_type;
endpackage

/* File: src/uart_ident_format.sv */
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Identification read returns the held code, highest pending when it latched
// - Reported interrupt held until serviced
// - Read clears only the reported interrupt
// - Line status: level 1, code 0110
// - Receive data available: level 2, code 0100
// - Receive timeout: level 2, code 1100
// - Transmit holding empty: level 3, code 0010
// - Modem status: level 4, code 0000
// - Bits 7-6 show FIFO enable, default 0
// - Bits 5-4 always read zero
// - Bit 0 low when pending, resets high
// - Line format bit 7 selects divisor latch
// - Line format bit 6 forces break low
// - Parity field: none, odd, even
// - Field 111 forces parity 0; 001 odd
// - Stop bit length: 1, 1.5 or 2
// - Word length 5 to 8 bits
// - FIFO control bit 0 enables FIFOs
module uart_ident_format
    import uart_ident_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [3:0] address,
    input  wire logic       read,
    input  wire logic       write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0] byteenable,
    output logic [31:0]     readdata,
    output logic            waitrequest,
    input  wire logic       lineStatusEvent,
    input  wire logic       rxAvailEvent,
    input  wire logic       rxTimeoutEvent,
    input  wire logic       txEmptyEvent,
    input  wire logic       modemEvent,
    output logic            fifoEnable,
    output logic            divisorAccess,
    output logic            breakForce,
    output logic [1:0]      parityMode,
    output logic            twoStops,
    output logic            halfStop,
    output logic [3:0]      wordLength,
    output logic            irqPending
);
    logic        rstMeta_reg;
    logic        rstSync_reg;
    logic [7:0]  lineFmt_reg;
    logic        fifoOn_reg;
    logic [4:0]  pend_reg;
    logic [4:0]  clearMask;
    logic [3:0]  held_reg;
    logic        heldValid_reg;
    logic        busy_reg;
    logic [3:0]  topCode;
    logic [4:0]  topMask;
    logic [4:0]  events;
    logic        identRead;
    logic        accept;
    logic [3:0]  shown_reg;
    parity_type  parityNext;

    localparam logic [3:0] WORD_LEN_MIN = 4'h5;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_type;

    bus_state_type busState_reg;
    bus_state_type busState_next;

    // Release is delayed two edges so every flop on rstSync_reg leaves reset together
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // Each request waits one cycle so read data come from a flop
    assign accept    = (read | write) & busy_reg;
    assign identRead = read & busy_reg & (address == ADDR_IDENT);
    assign events = {modemEvent, txEmptyEvent, rxTimeoutEvent,
                     rxAvailEvent, lineStatusEvent};

    // Bus sequencer: one wait cycle per request
    always_comb begin
        busState_next = busState_reg;
        case (busState_reg)
            BUS_IDLE: begin
                if (read | write) begin
                    busState_next = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                busState_next = BUS_IDLE;
            end
            default: begin
                busState_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            busState_reg <= BUS_IDLE;
            busy_reg     <= 1'b0;
            waitrequest  <= 1'b1;
        end else begin
            busState_reg <= busState_next;
            busy_reg     <= (busState_next == BUS_ANSWER);
            waitrequest  <= (busState_next != BUS_ANSWER);
        end
    end

    // Fixed priority over sticky sources
    always_comb begin
        topCode = ID_NONE;
        topMask = 5'h00;
        if (pend_reg[SRC_LINE]) begin
            topCode = ID_LINE_STATUS;
            topMask = 5'h01;
        end else if (pend_reg[SRC_RXAVAIL]) begin
            topCode = ID_RX_AVAIL;
            topMask = 5'h02;
        end else if (pend_reg[SRC_RXTIME]) begin
            topCode = ID_RX_TIMEOUT;
            topMask = 5'h04;
        end else if (pend_reg[SRC_TXEMPTY]) begin
            topCode = ID_TX_EMPTY;
            topMask = 5'h08;
        end else if (pend_reg[SRC_MODEM]) begin
            topCode = ID_MODEM;
            topMask = 5'h10;
        end
    end

    // A read clears only what that read showed; set wins in the cell
    always_comb begin
        clearMask = 5'h00;
        if (identRead) begin
            clearMask = heldMaskOf(shown_reg);
        end
    end

    // Maps a shown code back to its source bit
    function automatic logic [4:0] heldMaskOf(input logic [3:0] code);
        case (code)
            ID_LINE_STATUS: heldMaskOf = 5'h01;
            ID_RX_AVAIL:    heldMaskOf = 5'h02;
            ID_RX_TIMEOUT:  heldMaskOf = 5'h04;
            ID_TX_EMPTY:    heldMaskOf = 5'h08;
            ID_MODEM:       heldMaskOf = 5'h10;
            default:        heldMaskOf = 5'h00;
        endcase
    endfunction

    // One sticky cell per source
    pending_source #(
        .RESET_VALUE (1'b0)
    ) u_src_line (
        .clk_sys    (clk_sys),
        .resetn     (rstSync_reg),
        .setEvent   (events[SRC_LINE]),
        .clearPulse (clearMask[SRC_LINE]),
        .pending    (pend_reg[SRC_LINE])
    );

    pending_source #(
        .RESET_VALUE (1'b0)
    ) u_src_rx_avail (
        .clk_sys    (clk_sys),
        .resetn     (rstSync_reg),
        .setEvent   (events[SRC_RXAVAIL]),
        .clearPulse (clearMask[SRC_RXAVAIL]),
        .pending    (pend_reg[SRC_RXAVAIL])
    );

    pending_source #(
        .RESET_VALUE (1'b0)
    ) u_src_rx_time (
        .clk_sys    (clk_sys),
        .resetn     (rstSync_reg),
        .setEvent   (events[SRC_RXTIME]),
        .clearPulse (clearMask[SRC_RXTIME]),
        .pending    (pend_reg[SRC_RXTIME])
    );

    pending_source #(
        .RESET_VALUE (1'b0)
    ) u_src_tx_empty (
        .clk_sys    (clk_sys),
        .resetn     (rstSync_reg),
        .setEvent   (events[SRC_TXEMPTY]),
        .clearPulse (clearMask[SRC_TXEMPTY]),
        .pending    (pend_reg[SRC_TXEMPTY])
    );

    pending_source #(
        .RESET_VALUE (1'b0)
    ) u_src_modem (
        .clk_sys    (clk_sys),
        .resetn     (rstSync_reg),
        .setEvent   (events[SRC_MODEM]),
        .clearPulse (clearMask[SRC_MODEM]),
        .pending    (pend_reg[SRC_MODEM])
    );

    // Reported code latches and stays until a read services it
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            held_reg      <= ID_NONE;
            heldValid_reg <= 1'b0;
        end else if (!heldValid_reg || identRead) begin
            held_reg      <= (topMask != 5'h00) ? topCode : ID_NONE;
            heldValid_reg <= (topMask != 5'h00) && !identRead;
        end else begin
            held_reg      <= held_reg;
        end
    end

    // Code seen by a read in flight; later arrivals cannot be cleared
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            shown_reg <= ID_NONE;
        end else if (read && !busy_reg && address == ADDR_IDENT) begin
            shown_reg <= heldValid_reg ? held_reg : ID_NONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            lineFmt_reg <= LINE_FMT_RESET;
        end else if (accept && write && byteenable[0]
                     && address == ADDR_LINE_FMT) begin
            lineFmt_reg <= writedata[7:0];
        end
    end

    // Only lane 0 matters; other FIFO control bits are not kept
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            fifoOn_reg <= 1'b0;
        end else if (accept && write && byteenable[0]
                     && address == ADDR_FIFO_CTRL) begin
            fifoOn_reg <= writedata[FC_ENABLE];
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            readdata <= 32'h0000_0000;
        end else if (read && !busy_reg) begin
            case (address)
                ADDR_IDENT: begin
                    readdata <= {24'h000000,
                                 fifoOn_reg ? FIFO_ON_MARK : 2'h0,
                                 2'h0,
                                 heldValid_reg ? held_reg : ID_NONE};
                end
                ADDR_LINE_FMT:  readdata <= {24'h000000, lineFmt_reg};
                ADDR_FIFO_CTRL: readdata <= {31'h0, fifoOn_reg};
                ADDR_SOURCES:   readdata <= {27'h0, pend_reg};
                default:        readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Parity decode; 001 and 101 both read as odd
    always_comb begin
        parityNext = PARITY_ODD;
        if (!lineFmt_reg[LF_PAR_LO]) begin
            parityNext = PARITY_NONE;
        end else if (lineFmt_reg[LF_PAR_HI:LF_PAR_LO] == PAR_FORCE0) begin
            parityNext = PARITY_ZERO;
        end else if (lineFmt_reg[LF_PAR_HI:LF_PAR_LO] == PAR_EVEN) begin
            parityNext = PARITY_EVEN;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            fifoEnable    <= 1'b0;
            divisorAccess <= 1'b0;
            breakForce    <= 1'b0;
        end else begin
            fifoEnable    <= fifoOn_reg;
            divisorAccess <= lineFmt_reg[LF_DIVISOR];
            breakForce    <= lineFmt_reg[LF_BREAK];
        end
    end

    // Serial framing handed to the shifters
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            parityMode <= PARITY_NONE;
            twoStops   <= 1'b0;
            halfStop   <= 1'b0;
            wordLength <= WORD_LEN_MIN;
        end else begin
            parityMode <= parityNext;
            twoStops <= lineFmt_reg[LF_STOP] &
                        (lineFmt_reg[LF_LEN_HI:LF_LEN_LO] != 2'h0);
            halfStop <= lineFmt_reg[LF_STOP] &
                        (lineFmt_reg[LF_LEN_HI:LF_LEN_LO] == 2'h0);
            wordLength <= WORD_LEN_MIN +
                          {2'h0, lineFmt_reg[LF_LEN_HI:LF_LEN_LO]};
        end
    end

    // Level view of pending work, for the interrupt pin logic
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            irqPending <= 1'b0;
        end else begin
            irqPending <= heldValid_reg | (pend_reg != 5'h00);
        end
    end
endmodule

module pending_source #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic setEvent,
    input  wire logic clearPulse,
    output logic      pending
);
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pending <= RESET_VALUE;
        end else if (setEvent) begin
            pending <= 1'b1;
        end else if (clearPulse) begin
            pending <= 1'b0;
        end
    end
endmodule

/* File: testbench/avalon_host.sv */
`timescale 1ns/1ps
module avalon_host (
    input  wire logic        clk,
    input  wire logic        waitrequest,
    output logic [3:0]  address,
    output logic        read,
    output logic        write,
    output logic [31:0] writedata,
    output logic [3:0]  byteenable
);
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
    end
    // Held until waitrequest low; one idle edge before the next
    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [31:0] d);
        address <= a;
        writedata <= d;
        byteenable <= 4'hF;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d;
        byteenable <= 4'h0;
        @(posedge clk);
    endtask
endmodule

/* File: testbench/uart_ident_format_properties.sv */
`timescale 1ns/1ps
module uart_ident_format_properties
    import uart_ident_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        fifoEnable,
    input wire logic        divisorAccess,
    input wire logic        breakForce,
    input wire logic [1:0]  parityMode,
    input wire logic        twoStops,
    input wire logic        halfStop,
    input wire logic [3:0]  wordLength,
    input wire logic        irqPending
);
    logic [7:0] fmt_reg;
    logic       fifo_reg;
    logic [1:0] age_reg;
    wire        wrOk = write && !waitrequest && byteenable[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Shadow copies; outputs judged once settled
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fmt_reg <= 8'h00;
            fifo_reg <= 1'b0;
            age_reg <= 2'h3;
        end else if (wrOk && address == ADDR_LINE_FMT) begin
            fmt_reg <= writedata[7:0];
            age_reg <= 2'h0;
        end else if (wrOk && address == ADDR_FIFO_CTRL) begin
            fifo_reg <= writedata[0];
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    sequence identRead;
        read && !waitrequest && address == ADDR_IDENT;
    endsequence
    sequence settled;
        age_reg == 2'h3;
    endsequence
    AST_ONE_WAIT: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("no answer after one wait");
    AST_IDLE_BITS: assert property (identRead |-> readdata[5:4] == 2'h0
        && readdata[31:8] == 24'h0) else $error("unused ident bits set");
    AST_FIFO_MARK: assert property (identRead |->
        readdata[7:6] == {2{fifo_reg}}) else $error("fifo mark wrong");
    AST_NONE_BIT: assert property (identRead ##0 readdata[0] |->
        readdata[3:1] == 3'h0) else $error("none code malformed");
    AST_IRQ_PEND: assert property (identRead ##0 !readdata[0] |->
        irqPending) else $error("pending flag low while code shown");
    AST_FIFO_OUT: assert property (settled |-> fifoEnable == fifo_reg)
        else $error("fifo enable wrong");
    AST_DIVISOR: assert property (settled |-> divisorAccess == fmt_reg[7])
        else $error("divisor access wrong");
    AST_BREAK: assert property (settled |-> breakForce == fmt_reg[6])
        else $error("break wrong");
    AST_PARITY: assert property (settled |-> parityMode ==
        (!fmt_reg[3] ? 2'h0 : !fmt_reg[4] ? 2'h1 : fmt_reg[5] ? 2'h3 : 2'h2))
        else $error("parity mode wrong");
    AST_STOPS: assert property (settled |->
        twoStops == (fmt_reg[2] && fmt_reg[1:0] != 2'h0) &&
        halfStop == (fmt_reg[2] && fmt_reg[1:0] == 2'h0))
        else $error("stop bits wrong");
    AST_WORD_LEN: assert property (settled |->
        wordLength == 4'h5 + {2'h0, fmt_reg[1:0]}) else $error("length wrong");
endmodule

bind uart_ident_format uart_ident_format_properties u_props (.*);

/* File: testbench/uart_interrupt_id_and_line_format_bench.sv */
`timescale 1ns/1ps
module uart_interrupt_id_and_line_format_bench;
    import uart_ident_pkg::*;
    logic        clk_sys, resetn;
    logic [4:0]  ev;
    logic [3:0]  address, byteenable;
    logic        read, write, waitrequest;
    logic [31:0] writedata, readdata;
    logic [31:0] expq[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [3:0]  codes[6] = '{ID_LINE_STATUS, ID_RX_AVAIL, ID_RX_TIMEOUT,
                              ID_TX_EMPTY, ID_MODEM, ID_NONE};
    uart_ident_format u_uart_ident_format (.clk_sys(clk_sys),
        .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .lineStatusEvent(ev[4]),
        .rxAvailEvent(ev[3]), .rxTimeoutEvent(ev[2]), .txEmptyEvent(ev[1]),
        .modemEvent(ev[0]), .fifoEnable(), .divisorAccess(), .breakForce(),
        .parityMode(), .twoStops(), .halfStop(), .wordLength(),
        .irqPending());
    avalon_host u_avalon_host (.clk(clk_sys), .waitrequest(waitrequest),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t read %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        u_avalon_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic fire(input logic [4:0] s);
        ev <= s;
        @(posedge clk_sys);
        ev <= 5'h0;
        repeat (4) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys)
        if (read === 1'b1 && waitrequest === 1'b0 && expq.size() > 0)
            chk(readdata, expq.pop_front());
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #40000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [7:0] lf;
        ev = 5'h0;
        resetn = 1'b0;
        void'($urandom(75123));
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(ADDR_IDENT, {24'h0, IDENT_RESET});
        rd(ADDR_LINE_FMT, {24'h0, LINE_FMT_RESET});
        for (int f = 0; f < 2; f++) begin
            u_avalon_host.xfer(1'b1, ADDR_FIFO_CTRL, f);
            fire(5'h1F);
            rd(ADDR_SOURCES, 32'h0000001F);
            for (int i = 0; i < 6; i++)
                rd(ADDR_IDENT, {24'h0, {2{f[0]}}, 2'h0, codes[i]});
        end
        fire(5'h01);
        fire(5'h10);
        rd(ADDR_IDENT, {24'h0, FIFO_ON_MARK, 2'h0, ID_MODEM});
        u_avalon_host.xfer(1'b1, ADDR_IDENT, 32'hFF);
        rd(ADDR_IDENT, {24'h0, FIFO_ON_MARK, 2'h0, ID_LINE_STATUS});
        rd(4'h2, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lf = $urandom;
            lf[5:3] = i[2:0];
            u_avalon_host.xfer(1'b1, ADDR_LINE_FMT, {24'h0, lf});
            rd(ADDR_LINE_FMT, {24'h0, lf});
        end
        wrap_up();
    end
endmodule
